/* design/tpo_params.svh */
// Register offsets, field positions, field widths and reset values of the output stage.
`ifndef TPO_PARAMS_SVH
`define TPO_PARAMS_SVH
`define TPO_ADDR_W 8
`define TPO_DATA_W 16
`define TPO_ADDR_CONTROL 8'h00
`define TPO_ADDR_STATUS 8'h04
`define TPO_ADDR_PERIOD 8'h08
`define TPO_ADDR_DEAD 8'h0c
`define TPO_ADDR_CHOP 8'h10
`define TPO_ADDR_MASK 8'h14
`define TPO_ADDR_SYNCW 8'h18
`define TPO_ADDR_DUTY_A 8'h1c
`define TPO_ADDR_DUTY_B 8'h20
`define TPO_ADDR_DUTY_C 8'h24
`define TPO_CTRL_ENABLE 0
`define TPO_CTRL_SYNC_EN 1
`define TPO_CTRL_DOUBLE 2
`define TPO_CTRL_EXT_TIMING 3
`define TPO_CTRL_SYNC_SRC 4
`define TPO_CTRL_W 5
`define TPO_STA_HALF 0
`define TPO_STA_TRIP_LEVEL 3
`define TPO_STA_TRIP_FLAG 8
`define TPO_STA_SYNC_FLAG 9
`define TPO_CHOP_DIV_W 8
`define TPO_CHOP_HI 8
`define TPO_CHOP_LO 9
`define TPO_CHOP_W 10
`define TPO_MASK_W 9
`define TPO_XOVR_PAIR0 8
`define TPO_XOVR_PAIR1 7
`define TPO_XOVR_PAIR2 6
`define TPO_MASK_A_LOW 5
`define TPO_MASK_A_HIGH 4
`define TPO_MASK_B_LOW 3
`define TPO_MASK_B_HIGH 2
`define TPO_MASK_C_LOW 1
`define TPO_MASK_C_HIGH 0
`define TPO_DEAD_W 10
`define TPO_SYNCW_W 10
`define TPO_RST_CONTROL 5'h00
`define TPO_RST_CHOP 10'h000
`define TPO_RST_MASK 9'h000
`define TPO_RST_SYNCW 10'h001
`define TPO_CHOP_CNT_W 10
`endif

/* design/tpo_pkg.sv */
// Types shared by the three-phase PWM output stage.
package tpo_pkg;
`include "tpo_params.svh"
  typedef enum logic [2:0] {
    MODE_IDLE = 3'b001,
    MODE_RUN = 3'b010,
    MODE_TRIP = 3'b100
  } tpo_mode_t;

  typedef struct packed {
    logic [`TPO_CTRL_W-1:0] control;
    logic [`TPO_DATA_W-1:0] switching_period;
    logic [`TPO_DEAD_W-1:0] dead_time;
    logic [`TPO_CHOP_W-1:0] gate_chop_config;
    logic [`TPO_MASK_W-1:0] output_mask_crossover;
    logic [`TPO_SYNCW_W-1:0] sync_pulse_width;
    logic [2:0][`TPO_DATA_W-1:0] duty;
    logic [`TPO_DATA_W-1:0] work_period;
    logic [`TPO_DEAD_W-1:0] work_dead;
    logic [2:0][`TPO_DATA_W-1:0] work_duty;
    logic [`TPO_MASK_W-1:0] work_mask;
    logic [3:0] written;
    tpo_mode_t mode;
    logic [`TPO_DATA_W-1:0] count;
    logic half;
    logic [`TPO_SYNCW_W-1:0] sync_count;
    logic sync_pulse;
    logic sync_flag;
    logic trip_flag;
    logic [`TPO_CHOP_CNT_W-1:0] chop_count;
    logic trip_meta;
    logic trip_sync;
    logic ext_meta;
    logic ext_sync;
    logic ext_sync_prev;
    logic ext_direct;
    logic ext_direct_prev;
    logic [`TPO_DATA_W-1:0] rd_data;
  } tpo_state_t;
endpackage : tpo_pkg

/* design/tpo_output_stage.sv */
// Three-phase PWM output stage with crossover, masking, gate chopping and trip shutdown.
//
// Contract
// - Reset clears all three pair crossover bits.
// - A set mask bit holds its output off whatever the duty.
// - Masking acts after the crossover swap, on the physical pin.
// - Reset clears all six mask bits, enabling every output.
// - Mask and crossover working copy loads only on sync pulse rising edge.
// - High-side chop enable chops the active phase of all high outputs.
// - Low-side chop enable chops the active phase of all low outputs.
// - Chop carrier period is four times divider plus one core cycles.
// - Reset clears the whole chop configuration register.
// - Low trip input forces all six outputs high asynchronously.
// - No sync pulse is generated during a fault shutdown.
// - Status shows the live trip input level.
// - A trip raises the trip flag and halts timing.
// - After trip, period and duties are rewritten; timing resumes once trip high.
// - Control bit 4 picks external or internal sync source.
// - Control bit 3 treats external sync as synchronous or asynchronous.
// - Control bit 2 selects double or single update mode.
// - Control bit 1 enables synchronisation to the external sync.
// - Control bit 0 enables the controller; a trip clears it.
// - Status bit 9 flags the sync pulse event.
// - Period is 16 bits, dead time and sync width 10 bits.
// - Mask bits 8, 7, 6 swap high and low of pairs 0, 1, 2.
// - Outputs are active low; high is off.
// - Status bit 8 is the trip flag, bit 0 the half-cycle phase.
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module tpo_output_stage
  import tpo_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [`TPO_ADDR_W-1:0] bus_addr,
  input wire logic [`TPO_DATA_W-1:0] bus_wr_data,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [`TPO_DATA_W-1:0] bus_rd_data,
  input wire logic fault_trip_input,
  input wire logic external_sync,
  output logic cycle_sync_pulse,
  output logic phase_a_high_out_n,
  output logic phase_a_low_out_n,
  output logic phase_b_high_out_n,
  output logic phase_b_low_out_n,
  output logic phase_c_high_out_n,
  output logic phase_c_low_out_n
);

  localparam int unsigned XOVR_BIT [3] = '{`TPO_XOVR_PAIR0, `TPO_XOVR_PAIR1, `TPO_XOVR_PAIR2};
  localparam int unsigned MASK_HI_BIT [3] = '{`TPO_MASK_A_HIGH, `TPO_MASK_B_HIGH,
                                            `TPO_MASK_C_HIGH};
  localparam int unsigned MASK_LO_BIT [3] = '{`TPO_MASK_A_LOW, `TPO_MASK_B_LOW,
                                            `TPO_MASK_C_LOW};

  tpo_state_t r;
  tpo_state_t next_r;
  logic [5:0] out_n;
  logic [5:0] next_out_n;
  logic out_clear_n;

  // Duty less dead time, stopping at zero.
  function automatic logic [`TPO_DATA_W-1:0] sat_sub(input logic [`TPO_DATA_W-1:0] a,
                                                    input logic [`TPO_DEAD_W-1:0] b);
    logic [`TPO_DATA_W:0] diff;
    diff = {1'b0, a} - {7'h00, b};
    sat_sub = diff[`TPO_DATA_W] ? '0 : diff[`TPO_DATA_W-1:0];
  endfunction : sat_sub

  // Period value that never drops below one count.
  function automatic logic [`TPO_DATA_W-1:0] safe_period(input logic [`TPO_DATA_W-1:0] p);
    safe_period = (p == '0) ? 16'h0001 : p;
  endfunction : safe_period

  logic ext_edge;
  logic int_start;
  logic int_mid;
  logic update_strobe;
  logic trip_now;
  logic all_written;
  logic carrier;
  logic [2:0] high_on;
  logic [2:0] low_on;
  logic [2:0] pin_high_on;
  logic [2:0] pin_low_on;
  logic [`TPO_DATA_W:0] low_edge;
  logic [`TPO_CHOP_CNT_W-1:0] chop_limit;
  logic [`TPO_CHOP_CNT_W-1:0] chop_half;
  logic read_status;

  always_comb begin
    next_r = r;
    ext_edge = 1'b0;
    int_start = 1'b0;
    int_mid = 1'b0;
    update_strobe = 1'b0;
    high_on = '0;
    low_on = '0;
    pin_high_on = '0;
    pin_low_on = '0;
    low_edge = '0;
    next_out_n = '1;
    read_status = 1'b0;

    // Input synchronisers for the trip pin and the external sync pin.
    next_r.trip_meta = fault_trip_input;
    next_r.trip_sync = r.trip_meta;
    next_r.ext_meta = external_sync;
    next_r.ext_sync = r.ext_meta;
    next_r.ext_sync_prev = r.ext_sync;
    next_r.ext_direct = external_sync;
    next_r.ext_direct_prev = r.ext_direct;
    trip_now = ~r.trip_sync;
    if (r.control[`TPO_CTRL_EXT_TIMING]) begin
      ext_edge = r.ext_direct & ~r.ext_direct_prev;
    end else begin
      ext_edge = r.ext_sync & ~r.ext_sync_prev;
    end

    // Register writes.
    if (bus_wr) begin
      if (bus_addr == `TPO_ADDR_CONTROL) begin
        next_r.control = bus_wr_data[`TPO_CTRL_W-1:0];
      end else if (bus_addr == `TPO_ADDR_PERIOD) begin
        next_r.switching_period = bus_wr_data;
        next_r.written[3] = 1'b1;
      end else if (bus_addr == `TPO_ADDR_DEAD) begin
        next_r.dead_time = bus_wr_data[`TPO_DEAD_W-1:0];
      end else if (bus_addr == `TPO_ADDR_CHOP) begin
        next_r.gate_chop_config = bus_wr_data[`TPO_CHOP_W-1:0];
      end else if (bus_addr == `TPO_ADDR_MASK) begin
        next_r.output_mask_crossover = bus_wr_data[`TPO_MASK_W-1:0];
      end else if (bus_addr == `TPO_ADDR_SYNCW) begin
        next_r.sync_pulse_width = bus_wr_data[`TPO_SYNCW_W-1:0];
      end else if (bus_addr == `TPO_ADDR_DUTY_A) begin
        next_r.duty[0] = bus_wr_data;
        next_r.written[0] = 1'b1;
      end else if (bus_addr == `TPO_ADDR_DUTY_B) begin
        next_r.duty[1] = bus_wr_data;
        next_r.written[1] = 1'b1;
      end else if (bus_addr == `TPO_ADDR_DUTY_C) begin
        next_r.duty[2] = bus_wr_data;
        next_r.written[2] = 1'b1;
      end
    end
    all_written = &next_r.written;

    // Period counter: first half counts down, second half counts up.
    case (r.mode)
      MODE_IDLE: begin
        next_r.half = 1'b0;
        next_r.work_period = r.switching_period;
        next_r.work_dead = r.dead_time;
        next_r.work_duty = r.duty;
        if (r.control[`TPO_CTRL_ENABLE] && all_written && !trip_now) begin
          next_r.mode = MODE_RUN;
          next_r.count = safe_period(r.switching_period) - 16'h0001;
          int_start = 1'b1;
        end
      end
      MODE_RUN: begin
        if (!r.control[`TPO_CTRL_ENABLE]) begin
          next_r.mode = MODE_IDLE;
        end else if (r.control[`TPO_CTRL_SYNC_SRC] && r.control[`TPO_CTRL_SYNC_EN]
                     && ext_edge) begin
          next_r.half = 1'b0;
          next_r.count = safe_period(r.switching_period) - 16'h0001;
          int_start = 1'b1;
        end else if (!r.half) begin
          if (r.count == '0) begin
            next_r.half = 1'b1;
            int_mid = 1'b1;
          end else begin
            next_r.count = r.count - 16'h0001;
          end
        end else begin
          if (r.count >= safe_period(r.work_period) - 16'h0001) begin
            next_r.half = 1'b0;
            next_r.count = safe_period(r.switching_period) - 16'h0001;
            int_start = 1'b1;
          end else begin
            next_r.count = r.count + 16'h0001;
          end
        end
      end
      MODE_TRIP: begin
        next_r.half = 1'b0;
        if (!trip_now) begin
          next_r.mode = MODE_IDLE;
        end
      end
      default: begin
        next_r.mode = MODE_IDLE;
      end
    endcase

    // Sync events latch working copies on the rising edge of the sync pulse.
    if (r.mode == MODE_RUN && !trip_now) begin
      if (r.control[`TPO_CTRL_SYNC_SRC]) begin
        update_strobe = ext_edge;
      end else begin
        update_strobe = int_start | (int_mid & r.control[`TPO_CTRL_DOUBLE]);
      end
    end
    if (update_strobe) begin
      next_r.work_mask = r.output_mask_crossover;
      next_r.work_period = r.switching_period;
      next_r.work_dead = r.dead_time;
      next_r.work_duty = next_r.duty;
      next_r.sync_count = (r.sync_pulse_width == '0) ? 10'h001 : r.sync_pulse_width;
    end else if (r.sync_count != '0) begin
      next_r.sync_count = r.sync_count - 10'h001;
    end
    next_r.sync_pulse = (next_r.sync_count != '0) && !trip_now;

    // Trip shutdown halts timing and clears the enable and rewrite bookkeeping.
    if (trip_now) begin
      next_r.mode = MODE_TRIP;
      next_r.control[`TPO_CTRL_ENABLE] = 1'b0;
      next_r.written = '0;
      next_r.sync_count = '0;
    end

    // Status reads clear the event flags, but a new event wins.
    read_status = bus_rd && (bus_addr == `TPO_ADDR_STATUS);
    next_r.sync_flag = update_strobe | (r.sync_flag & ~read_status);
    next_r.trip_flag = (trip_now & (r.mode != MODE_TRIP)) | (r.trip_flag & ~read_status);

    // Read data, one cycle after the strobe.
    next_r.rd_data = '0;
    if (bus_rd) begin
      if (bus_addr == `TPO_ADDR_CONTROL) begin
        next_r.rd_data[`TPO_CTRL_W-1:0] = r.control;
      end else if (bus_addr == `TPO_ADDR_STATUS) begin
        next_r.rd_data[`TPO_STA_SYNC_FLAG] = r.sync_flag;
        next_r.rd_data[`TPO_STA_TRIP_FLAG] = r.trip_flag;
        next_r.rd_data[`TPO_STA_TRIP_LEVEL] = r.trip_sync;
        next_r.rd_data[`TPO_STA_HALF] = r.half;
      end else if (bus_addr == `TPO_ADDR_PERIOD) begin
        next_r.rd_data = r.switching_period;
      end else if (bus_addr == `TPO_ADDR_DEAD) begin
        next_r.rd_data[`TPO_DEAD_W-1:0] = r.dead_time;
      end else if (bus_addr == `TPO_ADDR_CHOP) begin
        next_r.rd_data[`TPO_CHOP_W-1:0] = r.gate_chop_config;
      end else if (bus_addr == `TPO_ADDR_MASK) begin
        next_r.rd_data[`TPO_MASK_W-1:0] = r.output_mask_crossover;
      end else if (bus_addr == `TPO_ADDR_SYNCW) begin
        next_r.rd_data[`TPO_SYNCW_W-1:0] = r.sync_pulse_width;
      end else if (bus_addr == `TPO_ADDR_DUTY_A) begin
        next_r.rd_data = r.duty[0];
      end else if (bus_addr == `TPO_ADDR_DUTY_B) begin
        next_r.rd_data = r.duty[1];
      end else if (bus_addr == `TPO_ADDR_DUTY_C) begin
        next_r.rd_data = r.duty[2];
      end
    end

    // Chop carrier: high for the first half of a 4*(div+1) cycle period.
    chop_limit = {r.gate_chop_config[`TPO_CHOP_DIV_W-1:0], 2'b11};
    chop_half = {1'b0, r.gate_chop_config[`TPO_CHOP_DIV_W-1:0], 1'b1};
    if (r.chop_count >= chop_limit) begin
      next_r.chop_count = '0;
    end else begin
      next_r.chop_count = r.chop_count + 10'h001;
    end
    carrier = (r.chop_count <= chop_half);

    // Timing signals, crossover, masking, chopping, then inversion to active low.
    for (int i = 0; i < 3; i++) begin
      low_edge = {1'b0, r.work_duty[i]} + {7'h00, r.work_dead};
      high_on[i] = (r.count < sat_sub(r.work_duty[i], r.work_dead));
      low_on[i] = ({1'b0, r.count} >= low_edge);
      if (r.work_mask[XOVR_BIT[i]]) begin
        pin_high_on[i] = low_on[i];
        pin_low_on[i] = high_on[i];
      end else begin
        pin_high_on[i] = high_on[i];
        pin_low_on[i] = low_on[i];
      end
      pin_high_on[i] = pin_high_on[i] & ~r.work_mask[MASK_HI_BIT[i]];
      pin_low_on[i] = pin_low_on[i] & ~r.work_mask[MASK_LO_BIT[i]];
      if (r.gate_chop_config[`TPO_CHOP_HI]) begin
        pin_high_on[i] = pin_high_on[i] & carrier;
      end
      if (r.gate_chop_config[`TPO_CHOP_LO]) begin
        pin_low_on[i] = pin_low_on[i] & carrier;
      end
      if (r.mode == MODE_RUN && !trip_now) begin
        next_out_n[2*i+1] = ~pin_high_on[i];
        next_out_n[2*i] = ~pin_low_on[i];
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
      r.control <= `TPO_RST_CONTROL;
      r.gate_chop_config <= `TPO_RST_CHOP;
      r.output_mask_crossover <= `TPO_RST_MASK;
      r.work_mask <= `TPO_RST_MASK;
      r.sync_pulse_width <= `TPO_RST_SYNCW;
      r.mode <= MODE_IDLE;
      r.trip_meta <= 1'b1;
      r.trip_sync <= 1'b1;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  // The trip pin clears the output flops directly, so no clock edge is needed.
  assign out_clear_n = reset_n & fault_trip_input;

  always_ff @(posedge core_clk or negedge out_clear_n) begin
    if (!out_clear_n) begin
      out_n <= 6'h3f;
    end else if (clk_en) begin
      out_n <= next_out_n;
    end
  end

  assign bus_rd_data = r.rd_data;
  assign cycle_sync_pulse = r.sync_pulse;
  assign phase_a_high_out_n = out_n[1];
  assign phase_a_low_out_n = out_n[0];
  assign phase_b_high_out_n = out_n[3];
  assign phase_b_low_out_n = out_n[2];
  assign phase_c_high_out_n = out_n[5];
  assign phase_c_low_out_n = out_n[4];

endmodule : tpo_output_stage

/* tb/tpo_output_stage_properties.sv */
// Port-level assertions for the three-phase PWM output stage.
`timescale 1ns/1ps
`include "tpo_params.svh"
module tpo_output_stage_checker
  import tpo_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] bus_addr,
  input wire logic [15:0] bus_wr_data,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [15:0] bus_rd_data,
  input wire logic fault_trip_input,
  input wire logic external_sync,
  input wire logic cycle_sync_pulse,
  input wire logic phase_a_high_out_n,
  input wire logic phase_a_low_out_n,
  input wire logic phase_b_high_out_n,
  input wire logic phase_b_low_out_n,
  input wire logic phase_c_high_out_n,
  input wire logic phase_c_low_out_n
);
  logic [5:0] gate_n;
  assign gate_n = {phase_a_high_out_n, phase_a_low_out_n, phase_b_high_out_n,
    phase_b_low_out_n, phase_c_high_out_n, phase_c_low_out_n};
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  a_trip_forces_off: assert property (!fault_trip_input |-> gate_n == 6'h3f)
    else $error("Gate output on while trip is low.");
  a_trip_no_sync: assert property (!fault_trip_input [*4] |=> !cycle_sync_pulse)
    else $error("Sync pulse during shutdown.");
  a_trip_flag_level: assert property (!fault_trip_input [*4] ##1 (bus_rd &&
    bus_addr == `TPO_ADDR_STATUS && !fault_trip_input) |=> bus_rd_data[8] && !bus_rd_data[3])
    else $error("Trip status bits wrong.");
  a_rd_idle_zero: assert property (!$past(bus_rd) |-> bus_rd_data == 16'h0000)
    else $error("Read data not zero outside read.");
  a_status_reserved: assert property ($past(bus_rd) && $past(bus_addr) == `TPO_ADDR_STATUS
    |-> bus_rd_data[15:10] == 6'h00 && bus_rd_data[7:4] == 4'h0 && bus_rd_data[2:1] == 2'h0)
    else $error("Reserved status bits set.");
  a_ctrl_reserved: assert property ($past(bus_rd) && $past(bus_addr) == `TPO_ADDR_CONTROL
    |-> bus_rd_data[15:5] == 11'h000)
    else $error("Reserved control bits set.");
  a_field_widths: assert property ($past(bus_rd) && $past(bus_addr) inside
    {`TPO_ADDR_DEAD, `TPO_ADDR_SYNCW, `TPO_ADDR_CHOP} |-> bus_rd_data[15:10] == 6'h00)
    else $error("Ten-bit register too wide.");
  a_mask_width: assert property ($past(bus_rd) && $past(bus_addr) == `TPO_ADDR_MASK
    |-> bus_rd_data[15:9] == 7'h00)
    else $error("Mask register too wide.");
  a_unmapped_zero: assert property ($past(bus_rd) && $past(bus_addr) > 8'h24
    |-> bus_rd_data == 16'h0000)
    else $error("Unmapped read not zero.");
  a_pair_exclusive: assert property ((gate_n[5] | gate_n[4]) && (gate_n[3] | gate_n[2])
    && (gate_n[1] | gate_n[0]))
    else $error("Both switches of a pair on.");
endmodule : tpo_output_stage_checker
bind tpo_output_stage tpo_output_stage_checker tpo_output_stage_checker_i (
  .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .bus_addr(bus_addr),
  .bus_wr_data(bus_wr_data), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rd_data(bus_rd_data),
  .fault_trip_input(fault_trip_input), .external_sync(external_sync),
  .cycle_sync_pulse(cycle_sync_pulse), .phase_a_high_out_n(phase_a_high_out_n),
  .phase_a_low_out_n(phase_a_low_out_n), .phase_b_high_out_n(phase_b_high_out_n),
  .phase_b_low_out_n(phase_b_low_out_n), .phase_c_high_out_n(phase_c_high_out_n),
  .phase_c_low_out_n(phase_c_low_out_n)
);

/* tb/tpo_gate_model.sv */
// Inverter gate driver and fault source model facing the output stage.
`timescale 1ns/1ps
module tpo_gate_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [5:0] gate_n,
  input wire logic fault_req,
  output logic fault_n,
  output logic shoot_seen
);
  // The fault line is driven low while a fault is requested.
  assign fault_n = ~fault_req;
  // A pair with both switches on would short the inverter leg.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shoot_seen <= 1'b0;
    end else if (~(gate_n[5] | gate_n[4]) | ~(gate_n[3] | gate_n[2]) | ~(gate_n[1] | gate_n[0]))
    begin
      shoot_seen <= 1'b1;
    end
  end
endmodule : tpo_gate_model

/* tb/tpo_output_stage_test.sv */
// Self-checking bench for the three-phase PWM output stage.
`timescale 1ns/1ps
`include "tpo_params.svh"
module tpo_output_stage_test
  import tpo_pkg::*;
;
  logic core_clk, reset_n, clk_en, bus_wr, bus_rd, external_sync, fault_req;
  logic fault_trip_input, cycle_sync_pulse, shoot_seen;
  logic [7:0] bus_addr;
  logic [15:0] bus_wr_data, bus_rd_data, rd_val, v;
  logic [5:0] g;
  int n_fail, check_count, cyc, seed, k, d;
  int cnt[9];

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  tpo_output_stage tpo_output_stage_i (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .bus_addr(bus_addr),
    .bus_wr_data(bus_wr_data), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rd_data(bus_rd_data),
    .fault_trip_input(fault_trip_input), .external_sync(external_sync),
    .cycle_sync_pulse(cycle_sync_pulse), .phase_a_high_out_n(g[5]), .phase_a_low_out_n(g[4]),
    .phase_b_high_out_n(g[3]), .phase_b_low_out_n(g[2]), .phase_c_high_out_n(g[1]),
    .phase_c_low_out_n(g[0])
  );
  tpo_gate_model tpo_gate_model_i (.core_clk(core_clk), .reset_n(reset_n), .gate_n(g),
    .fault_req(fault_req), .fault_n(fault_trip_input), .shoot_seen(shoot_seen));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic wr(input logic [7:0] a, input logic [15:0] dat);
    @(posedge core_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wr_data <= dat;
    @(posedge core_clk);
    bus_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1 rd_val = bus_rd_data;
  endtask : rd

  task automatic meas(input int n);
    logic [5:0] p;
    cnt = '{default: 0};
    p = g;
    repeat (n) begin
      @(posedge core_clk);
      for (int j = 0; j < 6; j++) cnt[j] += int'(g[j] === 1'b0);
      cnt[6] += int'(cycle_sync_pulse === 1'b1);
      cnt[7] += int'(p[5] && !g[5]);
      cnt[8] += int'(p[2] && !g[2]);
      p = g;
    end
  endtask : meas

  task automatic wsync();
    int t;
    t = 0;
    while (cycle_sync_pulse !== 1'b1 && t < 300) begin
      @(posedge core_clk);
      t++;
    end
    chk(16'(t < 300), 16'h0001);
    @(posedge core_clk);
  endtask : wsync

  // Low-side on time is the rest of a 16-cycle period, with no dead time.
  function automatic logic [15:0] expon(input int duty, input bit hs, input bit off);
    expon = off ? 16'h0000 : 16'(hs ? 2 * duty : 16 - 2 * duty);
  endfunction : expon

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    seed = 32'h715e0ecb;
    {reset_n, bus_wr, bus_rd, external_sync, fault_req} = 5'h00;
    clk_en = 1'b1;
    bus_addr = 8'h00;
    bus_wr_data = 16'h0000;
    n_fail = 0;
    check_count = 0;
    cyc = 0;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(`TPO_ADDR_CONTROL);
    chk(rd_val, 16'h0000);
    rd(`TPO_ADDR_CHOP);
    chk(rd_val, 16'h0000);
    rd(`TPO_ADDR_MASK);
    chk(rd_val, 16'h0000);
    rd(8'h40);
    chk(rd_val, 16'h0000);
    $display("reset test done");
    for (k = 0; k < 4; k++) begin
      v = 16'($random(seed));
      wr(`TPO_ADDR_DEAD, v);
      rd(`TPO_ADDR_DEAD);
      chk(rd_val, v & 16'h03ff);
      wr(`TPO_ADDR_CHOP, v);
      rd(`TPO_ADDR_CHOP);
      chk(rd_val, v & 16'h03ff);
      wr(`TPO_ADDR_MASK, v);
      rd(`TPO_ADDR_MASK);
      chk(rd_val, v & 16'h01ff);
      wr(`TPO_ADDR_CONTROL, v & 16'h001e);
      rd(`TPO_ADDR_CONTROL);
      chk(rd_val, v & 16'h001e);
      wr(`TPO_ADDR_SYNCW, v);
      rd(`TPO_ADDR_SYNCW);
      chk(rd_val, v & 16'h03ff);
      wr(`TPO_ADDR_PERIOD, ~v);
      rd(`TPO_ADDR_PERIOD);
      chk(rd_val, ~v);
    end
    wr(`TPO_ADDR_SYNCW, 16'h0001);
    wr(`TPO_ADDR_CONTROL, 16'h0000);
    wr(`TPO_ADDR_DEAD, 16'h0000);
    wr(`TPO_ADDR_CHOP, 16'h0000);
    wr(`TPO_ADDR_MASK, 16'h0000);
    wr(`TPO_ADDR_PERIOD, 16'h0008);
    wr(`TPO_ADDR_DUTY_A, 16'h0004);
    wr(`TPO_ADDR_DUTY_B, 16'h0004);
    wr(`TPO_ADDR_DUTY_C, 16'h0004);
    $display("register test done");
    for (d = 0; d < 2; d++) begin
      wr(`TPO_ADDR_CONTROL, d ? 16'h0005 : 16'h0001);
      wsync();
      wsync();
      rd(`TPO_ADDR_STATUS);
      chk(16'(rd_val[9]), 16'h0001);
      meas(16);
      chk(16'(cnt[6]), 16'(d + 1));
      for (k = 0; k < 6; k++) chk(16'(cnt[k]), expon(4, k[0], 1'b0));
    end
    wr(`TPO_ADDR_DUTY_A, 16'h0002);
    for (k = 0; k < 4; k++) begin
      v = 16'($random(seed)) & 16'h0130;
      wr(`TPO_ADDR_MASK, v);
      wsync();
      wsync();
      meas(16);
      chk(16'(cnt[5]), expon(2, !v[8], v[4]));
      chk(16'(cnt[4]), expon(2, v[8], v[5]));
    end
    $display("mask test done");
    wr(`TPO_ADDR_MASK, 16'h0000);
    wr(`TPO_ADDR_DUTY_A, 16'h0008);
    wr(`TPO_ADDR_DUTY_B, 16'h0000);
    for (k = 1; k < 4; k++) begin
      d = $random(seed) & 3;
      wr(`TPO_ADDR_CONTROL, 16'h0000);
      wr(`TPO_ADDR_CHOP, 16'(k * 256 + d));
      wr(`TPO_ADDR_CONTROL, 16'h0001);
      wsync();
      wsync();
      meas(16 * (d + 1));
      chk(16'(cnt[5]), 16'((8 * (d + 1)) << !k[0]));
      chk(16'(cnt[7]), 16'(k[0] ? 4 : 0));
      chk(16'(cnt[2]), 16'((8 * (d + 1)) << !k[1]));
      chk(16'(cnt[8]), 16'(k[1] ? 4 : 0));
      chk(16'(cnt[4] + cnt[3]), 16'h0000);
    end
    $display("chop test done");
    wr(`TPO_ADDR_CHOP, 16'h0000);
    wr(`TPO_ADDR_DUTY_A, 16'h0004);
    wr(`TPO_ADDR_DUTY_B, 16'h0004);
    wsync();
    wsync();
    fault_req <= 1'b1;
    #1 chk(16'(g), 16'h003f);
    repeat (6) @(posedge core_clk);
    rd(`TPO_ADDR_STATUS);
    chk(rd_val & 16'h0108, 16'h0100);
    rd(`TPO_ADDR_CONTROL);
    chk(16'(rd_val[0]), 16'h0000);
    meas(40);
    chk(16'(cnt[6]), 16'h0000);
    fault_req <= 1'b0;
    wr(`TPO_ADDR_CONTROL, 16'h0001);
    meas(40);
    chk(16'(cnt[6]), 16'h0000);
    rd(`TPO_ADDR_STATUS);
    chk(rd_val & 16'h0008, 16'h0008);
    wr(`TPO_ADDR_PERIOD, 16'h0008);
    wr(`TPO_ADDR_DUTY_A, 16'h0004);
    wr(`TPO_ADDR_DUTY_B, 16'h0004);
    wr(`TPO_ADDR_DUTY_C, 16'h0004);
    wr(`TPO_ADDR_CONTROL, 16'h0001);
    wsync();
    meas(16);
    chk(16'(cnt[6]), 16'h0001);
    chk(16'(cnt[5]), expon(4, 1'b1, 1'b0));
    $display("trip test done");
    for (k = 0; k < 2; k++) begin
      wr(`TPO_ADDR_CONTROL, k ? 16'h001b : 16'h0013);
      repeat (3) @(posedge core_clk);
      external_sync <= 1'b1;
      meas(6);
      chk(16'(cnt[6]), 16'h0001);
      external_sync <= 1'b0;
      meas(30);
      chk(16'(cnt[6]), 16'h0000);
    end
    clk_en <= 1'b0;
    meas(20);
    chk(16'(cnt[7] + cnt[8]), 16'h0000);
    clk_en <= 1'b1;
    meas(20);
    chk(16'(cnt[7]), 16'h0002);
    chk(16'(shoot_seen), 16'h0000);
    $display("sync test done");
    end_sim();
  end
endmodule : tpo_output_stage_test
